// ==== common/psc_pkg.sv ====
package psc_pkg;
    localparam int NUM_PORTS = 10;
    localparam int NUM_FAST_PORTS = 2;
    localparam int PORT_W = 4;
    localparam int LEN_W = 12;
    localparam int CNT_W = 32;
    localparam int CTR_N = 30;

    localparam logic [LEN_W-1:0] LEN_MIN = 12'h040;
    localparam logic [LEN_W-1:0] LEN_127 = 12'h07F;
    localparam logic [LEN_W-1:0] LEN_255 = 12'h0FF;
    localparam logic [LEN_W-1:0] LEN_511 = 12'h1FF;
    localparam logic [LEN_W-1:0] LEN_1023 = 12'h3FF;
    localparam logic [LEN_W-1:0] LEN_MAX_STD = 12'h5EE;
    localparam logic [LEN_W-1:0] LEN_MAX_LONG = 12'h5FF;
    localparam int LATE_COL_BITS = 512;

    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;

    // Counter indices within one port's bank
    localparam int C_RX_GOOD = 0;
    localparam int C_RX_BCAST = 1;
    localparam int C_RX_MCAST = 2;
    localparam int C_TX_GOOD = 3;
    localparam int C_TX_BCAST = 4;
    localparam int C_TX_MCAST = 5;
    localparam int C_CRS_ERR = 6;
    localparam int C_COLL = 7;
    localparam int C_DEFER = 8;
    localparam int C_EXC_COL = 9;
    localparam int C_FILTER = 10;
    localparam int C_LATE_COL = 11;
    localparam int C_ALIGN_CODE = 12;
    localparam int C_MULTI_COL = 13;
    localparam int C_SINGLE_COL = 14;
    localparam int C_OCTETS = 15;
    localparam int C_OVERSIZE = 16;
    localparam int C_BIN64 = 17;
    localparam int C_BIN127 = 18;
    localparam int C_BIN255 = 19;
    localparam int C_BIN511 = 20;
    localparam int C_BIN1023 = 21;
    localparam int C_BINMAX = 22;
    localparam int C_CRC_ERR = 23;
    localparam int C_FRAG = 24;
    localparam int C_JABBER = 25;
    localparam int C_OVERRUN = 26;
    localparam int C_TX_DATA_ERR = 27;
    localparam int C_ADDR_MISM = 28;
    localparam int C_UNDERSIZE = 29;

    typedef struct packed {
        logic done;
        logic [PORT_W-1:0] port;
        logic [LEN_W-1:0] len;
        logic good;
        logic bcast;
        logic mcast;
        logic fcs_err;
        logic align_err;
        logic rx_er;
        logic discarded;
    } psc_rx_evt_t;

    typedef struct packed {
        logic done;
        logic [PORT_W-1:0] port;
        logic [LEN_W-1:0] len;
        logic success;
        logic bcast;
        logic mcast;
        logic [4:0] coll_cnt;
        logic deferred;
        logic excess_col;
        logic crc_mismatch;
        logic underrun;
        logic queue_drop;
    } psc_tx_evt_t;

    typedef struct packed {
        logic [PORT_W-1:0] port;
        logic jam;
        logic crs_lost;
        logic late_col;
        logic overrun;
        logic addr_mismatch;
    } psc_pulse_t;
endpackage

// ==== hdl/psc_port_stats.sv ====
`timescale 1ns/10ps
// Summary of operation
// [RL1] Count good broadcast receives, not multicast
// [RL2] Count broadcast transmits, not multicast
// [RL3] Carrier-sense error at most once per attempt
// [RL4] Ten-megabit ports count each jam as collision
// [RL5] Count frames whose first attempt deferred
// [RL6] Count frames abandoned on excessive collisions
// [RL7] Count every frame sent to discard
// [RL8] Count all good received frames
// [RL9] Count all successfully transmitted frames
// [RL10] Count collisions past 512 bit times
// [RL11] Count good multicast receives, not broadcast
// [RL12] Align on every port; plus rx-error on fast
// [RL13] Single or multiple collision before success
// [RL14] Add all received octets including FCS
// [RL15] Oversize above 1518, or 1535 when long
// [RL16] Shared rx/tx size bins by length
// [RL17] Long mode stretches top bin to 1535
// [RL18] Count whole-octet frames failing FCS
// [RL19] Count short frames with FCS/align error
// [RL20] Count long frames with FCS/align error
// [RL21] Count frame data refused by receive FIFO
// [RL22] Select bit picks transmit data-error meaning
// [RL23] Separate counter bank for every port
// [RL24] Address mismatch counted and suspends port
module psc_port_stats (
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic LONG_FRAMES_I,
    input wire logic TX_ERROR_COUNTER_SELECT_I,
    input wire psc_pkg::psc_rx_evt_t RX_EVT_I,
    input wire psc_pkg::psc_tx_evt_t TX_EVT_I,
    input wire psc_pkg::psc_pulse_t PULSE_I,
    input wire logic PULSE_VALID_I,
    input wire logic [psc_pkg::PORT_W-1:0] RD_PORT_I,
    input wire logic [4:0] RD_INDEX_I,
    output logic [psc_pkg::CNT_W-1:0] RD_DATA_O,
    output logic [psc_pkg::NUM_PORTS-1:0] PORT_SUSPEND_O
);
    import psc_pkg::*;

    logic [CNT_W-1:0] cnt_r [NUM_PORTS][CTR_N];
    logic [CNT_W-1:0] rd_data_r;
    logic [NUM_PORTS-1:0] suspend_r;
    logic [NUM_PORTS-1:0] crs_seen_r;
    logic [LEN_W-1:0] max_len;

    // One-bit increment vectors built per event source
    logic [CTR_N-1:0] rx_inc;
    logic [CTR_N-1:0] tx_inc;
    logic [CTR_N-1:0] pl_inc;
    logic [LEN_W-1:0] rx_oct;
    logic rx_fast;
    logic pl_fast;
    logic rx_bad;
    logic crs_count;
    logic rx_port_ok;
    logic tx_port_ok;
    logic pl_port_ok;

    function automatic logic [5:0] size_bins(input logic [LEN_W-1:0] len,
                                             input logic [LEN_W-1:0] top);
        size_bins[0] = (len == LEN_MIN);
        size_bins[1] = (len > LEN_MIN) && (len <= LEN_127);
        size_bins[2] = (len > LEN_127) && (len <= LEN_255);
        size_bins[3] = (len > LEN_255) && (len <= LEN_511);
        size_bins[4] = (len > LEN_511) && (len <= LEN_1023);
        size_bins[5] = (len > LEN_1023) && (len <= top);
    endfunction

    function automatic logic is_fast(input logic [PORT_W-1:0] p);
        is_fast = (32'(p) < NUM_FAST_PORTS);
    endfunction

    assign max_len = LONG_FRAMES_I ? LEN_MAX_LONG : LEN_MAX_STD; // [RL15] [RL17]
    assign rx_fast = is_fast(RX_EVT_I.port);
    assign pl_fast = is_fast(PULSE_I.port);
    assign rx_bad = RX_EVT_I.fcs_err | RX_EVT_I.align_err;
    assign rx_oct = RX_EVT_I.done ? RX_EVT_I.len : '0; // [RL14]
    assign rx_port_ok = 32'(RX_EVT_I.port) < NUM_PORTS;
    assign tx_port_ok = 32'(TX_EVT_I.port) < NUM_PORTS;
    assign pl_port_ok = 32'(PULSE_I.port) < NUM_PORTS;

    always_comb begin
        rx_inc = '0;
        if (RX_EVT_I.done) begin
            rx_inc[C_RX_GOOD] = RX_EVT_I.good; // [RL8]
            rx_inc[C_RX_BCAST] = RX_EVT_I.good & RX_EVT_I.bcast; // [RL1]
            rx_inc[C_RX_MCAST] = RX_EVT_I.good & RX_EVT_I.mcast
                & ~RX_EVT_I.bcast; // [RL11]
            rx_inc[C_FILTER] = RX_EVT_I.discarded; // [RL7]
            rx_inc[C_ALIGN_CODE] = RX_EVT_I.align_err
                | (rx_fast & RX_EVT_I.rx_er); // [RL12]
            rx_inc[C_OVERSIZE] = ~rx_bad & (RX_EVT_I.len > max_len); // [RL15]
            rx_inc[C_UNDERSIZE] = ~rx_bad & (RX_EVT_I.len < LEN_MIN);
            rx_inc[C_CRC_ERR] = RX_EVT_I.fcs_err
                & ~RX_EVT_I.align_err; // [RL18]
            rx_inc[C_FRAG] = rx_bad & (RX_EVT_I.len < LEN_MIN); // [RL19]
            rx_inc[C_JABBER] = rx_bad & (RX_EVT_I.len > max_len); // [RL20]
            rx_inc[C_BINMAX:C_BIN64] = size_bins(RX_EVT_I.len, max_len); // [RL16]
        end
    end

    always_comb begin
        tx_inc = '0;
        if (TX_EVT_I.done) begin
            tx_inc[C_TX_GOOD] = TX_EVT_I.success; // [RL9]
            tx_inc[C_TX_BCAST] = TX_EVT_I.success & TX_EVT_I.bcast; // [RL2]
            tx_inc[C_TX_MCAST] = TX_EVT_I.success & TX_EVT_I.mcast
                & ~TX_EVT_I.bcast;
            tx_inc[C_DEFER] = TX_EVT_I.deferred; // [RL5]
            tx_inc[C_EXC_COL] = TX_EVT_I.excess_col; // [RL6]
            tx_inc[C_SINGLE_COL] = TX_EVT_I.success
                & (TX_EVT_I.coll_cnt == 5'h01); // [RL13]
            tx_inc[C_MULTI_COL] = TX_EVT_I.success
                & (TX_EVT_I.coll_cnt > 5'h01); // [RL13]
            tx_inc[C_TX_DATA_ERR] = TX_ERROR_COUNTER_SELECT_I
                ? (TX_EVT_I.crc_mismatch | TX_EVT_I.underrun)
                : TX_EVT_I.queue_drop; // [RL22]
            if (TX_EVT_I.success) begin
                tx_inc[C_BINMAX:C_BIN64] = size_bins(TX_EVT_I.len,
                                                     max_len); // [RL16]
            end
        end
    end

    // Carrier loss inside an attempt is reported once; the latch clears
    // when the attempt finishes so the next attempt can count again.
    // Ports past the last one are dropped before the latch bit is used.
    assign crs_count = PULSE_VALID_I & PULSE_I.crs_lost
        & ~crs_seen_r[PULSE_I.port] & pl_port_ok; // [RL3]

    always_comb begin
        pl_inc = '0;
        if (PULSE_VALID_I) begin
            pl_inc[C_CRS_ERR] = crs_count; // [RL3]
            pl_inc[C_COLL] = PULSE_I.jam & ~pl_fast; // [RL4]
            pl_inc[C_LATE_COL] = PULSE_I.late_col; // [RL10]
            pl_inc[C_OVERRUN] = PULSE_I.overrun; // [RL21]
            pl_inc[C_ADDR_MISM] = PULSE_I.addr_mismatch; // [RL24]
        end
    end

    // Receive and transmit may both hit one size-bin counter in the same cycle, so the sum
    // is formed per counter rather than letting one source win.
    always_ff @(posedge CLOCK_I) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int c = 0; c < CTR_N; c++) begin
                if (SRST_I) begin
                    cnt_r[p][c] <= CNT_ZERO;
                end else begin
                    cnt_r[p][c] <= cnt_r[p][c]
                        + ((32'(RX_EVT_I.port) == p && rx_inc[c])
                           ? CNT_ONE : CNT_ZERO)
                        + ((32'(TX_EVT_I.port) == p && tx_inc[c])
                           ? CNT_ONE : CNT_ZERO)
                        + ((32'(PULSE_I.port) == p && pl_inc[c])
                           ? CNT_ONE : CNT_ZERO)
                        + ((32'(RX_EVT_I.port) == p && c == C_OCTETS)
                           ? CNT_W'(rx_oct) : CNT_ZERO); // [RL14] [RL23]
                end
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            crs_seen_r <= '0;
            suspend_r <= '0;
            rd_data_r <= CNT_ZERO;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                // Set beats clear: a loss in the closing cycle stays latched
                if (crs_count && 32'(PULSE_I.port) == p) begin
                    crs_seen_r[p] <= 1'b1; // [RL3]
                end else if (32'(TX_EVT_I.port) == p && TX_EVT_I.done) begin
                    crs_seen_r[p] <= 1'b0; // [RL3]
                end
                if (PULSE_VALID_I && PULSE_I.addr_mismatch
                    && 32'(PULSE_I.port) == p) begin
                    suspend_r[p] <= 1'b1; // [RL24]
                end
            end
            if (32'(RD_PORT_I) < NUM_PORTS && 32'(RD_INDEX_I) < CTR_N) begin
                rd_data_r <= cnt_r[RD_PORT_I][RD_INDEX_I];
            end else begin
                rd_data_r <= CNT_ZERO;
            end
        end
    end

    assign RD_DATA_O = rd_data_r;
    assign PORT_SUSPEND_O = suspend_r;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);

    sequence s_good_bcast_rx;
        RX_EVT_I.done && rx_port_ok && RX_EVT_I.good && RX_EVT_I.bcast;
    endsequence

    sequence s_rx_frame;
        RX_EVT_I.done && rx_port_ok;
    endsequence

    sequence s_tx_frame;
        TX_EVT_I.done && tx_port_ok;
    endsequence

    sequence s_pulse_ok;
        PULSE_VALID_I && pl_port_ok;
    endsequence

    chk_bcast_rx_count: assert property ( // [RL1]
        s_good_bcast_rx |=> cnt_r[$past(RX_EVT_I.port)][C_RX_BCAST]
            == $past(cnt_r[RX_EVT_I.port][C_RX_BCAST]) + CNT_ONE)
        else $error("broadcast rx not counted");

    chk_mcast_excl_bcast: assert property ( // [RL11]
        RX_EVT_I.done && RX_EVT_I.bcast |-> !rx_inc[C_RX_MCAST])
        else $error("broadcast counted as multicast");

    chk_crs_once: assert property ( // [RL3]
        crs_count |=> !(PULSE_VALID_I && PULSE_I.crs_lost
            && PULSE_I.port == $past(PULSE_I.port) && !TX_EVT_I.done
            && !$past(TX_EVT_I.done)) || !crs_count)
        else $error("carrier error counted twice");

    chk_jam_slow_only: assert property ( // [RL4]
        PULSE_VALID_I && PULSE_I.jam |-> pl_inc[C_COLL] == !pl_fast)
        else $error("jam collision wrong for port speed");

    chk_coll_bins: assert property ( // [RL13]
        TX_EVT_I.done && TX_EVT_I.success && TX_EVT_I.coll_cnt == 5'h01
            |-> tx_inc[C_SINGLE_COL] && !tx_inc[C_MULTI_COL])
        else $error("single collision miscounted");

    chk_align_code: assert property ( // [RL12]
        RX_EVT_I.done && rx_fast && RX_EVT_I.rx_er
            |-> rx_inc[C_ALIGN_CODE])
        else $error("fast port rx error not counted");

    chk_long_bin: assert property ( // [RL17]
        RX_EVT_I.done && LONG_FRAMES_I && RX_EVT_I.len == LEN_MAX_LONG
            |-> rx_inc[C_BINMAX] && !rx_inc[C_OVERSIZE])
        else $error("long frame bin wrong");

    chk_jabber_len: assert property ( // [RL20]
        RX_EVT_I.done && !LONG_FRAMES_I && RX_EVT_I.fcs_err
            && RX_EVT_I.len == LEN_MAX_LONG |-> rx_inc[C_JABBER])
        else $error("jabber not counted");

    chk_suspend_hold: assert property ( // [RL24]
        PULSE_VALID_I && pl_port_ok && PULSE_I.addr_mismatch
            |=> PORT_SUSPEND_O[$past(PULSE_I.port)]
            ##1 PORT_SUSPEND_O[$past(PULSE_I.port, 2)])
        else $error("port not suspended");

    chk_txerr_select: assert property ( // [RL22]
        TX_EVT_I.done && !TX_ERROR_COUNTER_SELECT_I
            |-> tx_inc[C_TX_DATA_ERR] == TX_EVT_I.queue_drop)
        else $error("tx data error select wrong");

    chk_good_rx_count: assert property ( // [RL8]
        s_rx_frame ##0 RX_EVT_I.good
            |=> cnt_r[$past(RX_EVT_I.port)][C_RX_GOOD]
            == $past(cnt_r[RX_EVT_I.port][C_RX_GOOD]) + CNT_ONE)
        else $error("good rx frame not counted");

    chk_mcast_rx_count: assert property ( // [RL11]
        s_rx_frame ##0 (RX_EVT_I.good && RX_EVT_I.mcast && !RX_EVT_I.bcast)
            |=> cnt_r[$past(RX_EVT_I.port)][C_RX_MCAST]
            == $past(cnt_r[RX_EVT_I.port][C_RX_MCAST]) + CNT_ONE)
        else $error("multicast rx not counted");

    chk_octet_sum: assert property ( // [RL14]
        s_rx_frame |=> cnt_r[$past(RX_EVT_I.port)][C_OCTETS]
            == $past(cnt_r[RX_EVT_I.port][C_OCTETS])
            + CNT_W'($past(RX_EVT_I.len)))
        else $error("octet count wrong");

    chk_good_tx_count: assert property ( // [RL9]
        s_tx_frame ##0 TX_EVT_I.success
            |=> cnt_r[$past(TX_EVT_I.port)][C_TX_GOOD]
            == $past(cnt_r[TX_EVT_I.port][C_TX_GOOD]) + CNT_ONE)
        else $error("good tx frame not counted");

    chk_defer_count: assert property ( // [RL5]
        s_tx_frame ##0 TX_EVT_I.deferred
            |=> cnt_r[$past(TX_EVT_I.port)][C_DEFER]
            == $past(cnt_r[TX_EVT_I.port][C_DEFER]) + CNT_ONE)
        else $error("deferred frame not counted");

    chk_jam_count: assert property ( // [RL4]
        s_pulse_ok ##0 (PULSE_I.jam && !pl_fast)
            |=> cnt_r[$past(PULSE_I.port)][C_COLL]
            == $past(cnt_r[PULSE_I.port][C_COLL]) + CNT_ONE)
        else $error("jam not counted as collision");

    chk_late_count: assert property ( // [RL10]
        s_pulse_ok ##0 PULSE_I.late_col
            |=> cnt_r[$past(PULSE_I.port)][C_LATE_COL]
            == $past(cnt_r[PULSE_I.port][C_LATE_COL]) + CNT_ONE)
        else $error("late collision not counted");

    chk_overrun_count: assert property ( // [RL21]
        s_pulse_ok ##0 PULSE_I.overrun
            |=> cnt_r[$past(PULSE_I.port)][C_OVERRUN]
            == $past(cnt_r[PULSE_I.port][C_OVERRUN]) + CNT_ONE)
        else $error("receive overrun not counted");

    chk_addr_count: assert property ( // [RL24]
        s_pulse_ok ##0 PULSE_I.addr_mismatch
            |=> cnt_r[$past(PULSE_I.port)][C_ADDR_MISM]
            == $past(cnt_r[PULSE_I.port][C_ADDR_MISM]) + CNT_ONE)
        else $error("address mismatch not counted");

    chk_oversize_std: assert property ( // [RL15]
        RX_EVT_I.done && !LONG_FRAMES_I && !rx_bad
            && RX_EVT_I.len > LEN_MAX_STD && RX_EVT_I.len <= LEN_MAX_LONG
            |-> rx_inc[C_OVERSIZE] && !rx_inc[C_BINMAX])
        else $error("oversize frame miscounted");

    chk_multi_coll: assert property ( // [RL13]
        TX_EVT_I.done && TX_EVT_I.success && TX_EVT_I.coll_cnt > 5'h01
            |-> tx_inc[C_MULTI_COL] && !tx_inc[C_SINGLE_COL])
        else $error("multiple collision miscounted");

    chk_txerr_alt: assert property ( // [RL22]
        TX_EVT_I.done && TX_ERROR_COUNTER_SELECT_I |-> tx_inc[C_TX_DATA_ERR]
            == (TX_EVT_I.crc_mismatch | TX_EVT_I.underrun))
        else $error("tx data error alternate select wrong");

    chk_crs_count: assert property ( // [RL3]
        crs_count |=> cnt_r[$past(PULSE_I.port)][C_CRS_ERR]
            == $past(cnt_r[PULSE_I.port][C_CRS_ERR]) + CNT_ONE)
        else $error("carrier error not counted");

    chk_bin_single: assert property ( // [RL16]
        RX_EVT_I.done && RX_EVT_I.len >= LEN_MIN && RX_EVT_I.len <= max_len
            |-> $onehot(rx_inc[C_BINMAX:C_BIN64]))
        else $error("rx frame not in exactly one bin");

    chk_frag_short: assert property ( // [RL19]
        RX_EVT_I.done && rx_bad && RX_EVT_I.len < LEN_MIN
            |-> rx_inc[C_FRAG] && !rx_inc[C_UNDERSIZE])
        else $error("fragment miscounted");

    chk_port_isolate: assert property ( // [RL23]
        !(RX_EVT_I.done && RX_EVT_I.port == '0)
            |=> cnt_r[0][C_RX_GOOD] == $past(cnt_r[0][C_RX_GOOD]))
        else $error("port zero counter moved by another port");

    chk_suspend_sticky: assert property ( // [RL24]
        !$past(SRST_I) |-> (PORT_SUSPEND_O & $past(PORT_SUSPEND_O))
            == $past(PORT_SUSPEND_O))
        else $error("port suspend dropped without reset");
endmodule

// ==== tb/psc_phy_model.sv ====
`timescale 1ns/10ps
module psc_phy_model (
    input wire logic clk_i,
    output psc_pkg::psc_rx_evt_t rx_o,
    output psc_pkg::psc_tx_evt_t tx_o,
    output psc_pkg::psc_pulse_t pu_o,
    output logic pv_o
);
    import psc_pkg::*;
    initial begin
        rx_o = '0;
        tx_o = '0;
        pu_o = '0;
        pv_o = 1'b0;
    end
    // One call per cycle; fields carry junk while done is low
    task automatic fire(input psc_rx_evt_t r, input psc_tx_evt_t t,
                        input psc_pulse_t u, input logic v);
        @(posedge clk_i);
        rx_o <= r;
        tx_o <= t;
        pu_o <= u;
        pv_o <= v;
    endtask
endmodule

// ==== tb/tb_port_statistics_counters.sv ====
`timescale 1ns/10ps
module tb_port_statistics_counters;
    import psc_pkg::*;
    localparam logic [LEN_W-1:0] LENS [15] = '{12'h03F, 12'h040, 12'h041,
        12'h07F, 12'h080, 12'h0FF, 12'h100, 12'h1FF, 12'h200, 12'h3FF,
        12'h400, 12'h5EE, 12'h5EF, 12'h5FF, 12'h600};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic long_r = 1'b0;
    logic sel = 1'b0;
    psc_rx_evt_t rx;
    psc_tx_evt_t tx;
    psc_pulse_t pu;
    logic pv;
    logic [PORT_W-1:0] rd_port = '0;
    logic [4:0] rd_idx = '0;
    logic [CNT_W-1:0] rd_data;
    logic [NUM_PORTS-1:0] susp;
    logic rd_req = 1'b0;
    logic rd_d = 1'b0;
    logic [CNT_W-1:0] exp_c [NUM_PORTS][CTR_N];
    logic [NUM_PORTS-1:0] exp_s;
    logic [NUM_PORTS-1:0] crs_l;
    logic [CNT_W-1:0] q [$];
    logic [15:0] lf = 16'h0008;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    psc_phy_model phy (.clk_i(clk), .rx_o(rx), .tx_o(tx), .pu_o(pu),
        .pv_o(pv));
    psc_port_stats uut (.CLOCK_I(clk), .SRST_I(srst),
        .LONG_FRAMES_I(long_r), .TX_ERROR_COUNTER_SELECT_I(sel),
        .RX_EVT_I(rx), .TX_EVT_I(tx), .PULSE_I(pu), .PULSE_VALID_I(pv),
        .RD_PORT_I(rd_port), .RD_INDEX_I(rd_idx), .RD_DATA_O(rd_data),
        .PORT_SUSPEND_O(susp));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic check(input string nm, input logic [CNT_W-1:0] seen,
                         input logic [CNT_W-1:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic inc(input int p, input int i);
        exp_c[p][i] = exp_c[p][i] + CNT_ONE;
    endtask
    function automatic int bin(input logic [LEN_W-1:0] l);
        if (l == LEN_MIN) return C_BIN64;
        if (l < LEN_MIN) return -1;
        if (l <= LEN_127) return C_BIN127;
        if (l <= LEN_255) return C_BIN255;
        if (l <= LEN_511) return C_BIN511;
        if (l <= LEN_1023) return C_BIN1023;
        if (l <= (long_r ? LEN_MAX_LONG : LEN_MAX_STD)) return C_BINMAX;
        return -1;
    endfunction
    task automatic upd(input psc_rx_evt_t r, input psc_tx_evt_t t,
                       input psc_pulse_t u, input logic v);
        logic [LEN_W-1:0] mx;
        int b;
        mx = long_r ? LEN_MAX_LONG : LEN_MAX_STD;
        if (r.done && r.port < NUM_PORTS) begin
            if (r.good) inc(r.port, C_RX_GOOD);
            if (r.good && r.bcast) inc(r.port, C_RX_BCAST);
            if (r.good && r.mcast && !r.bcast) inc(r.port, C_RX_MCAST);
            if (r.discarded) inc(r.port, C_FILTER);
            exp_c[r.port][C_OCTETS] += CNT_W'(r.len);
            b = bin(r.len);
            if (b >= 0) inc(r.port, b);
            if (r.fcs_err && !r.align_err) inc(r.port, C_CRC_ERR);
            if (r.align_err || (r.port < NUM_FAST_PORTS && r.rx_er)) begin
                inc(r.port, C_ALIGN_CODE);
            end
            if (r.fcs_err || r.align_err) begin
                if (r.len < LEN_MIN) inc(r.port, C_FRAG);
                if (r.len > mx) inc(r.port, C_JABBER);
            end else begin
                if (r.len < LEN_MIN) inc(r.port, C_UNDERSIZE);
                if (r.len > mx) inc(r.port, C_OVERSIZE);
            end
        end
        if (t.done && t.port < NUM_PORTS) begin
            crs_l[t.port] = 1'b0;
            if (t.success) begin
                inc(t.port, C_TX_GOOD);
                if (t.bcast) inc(t.port, C_TX_BCAST);
                if (t.mcast && !t.bcast) inc(t.port, C_TX_MCAST);
                b = bin(t.len);
                if (b >= 0) inc(t.port, b);
                if (t.coll_cnt == 5'h01) inc(t.port, C_SINGLE_COL);
                if (t.coll_cnt > 5'h01) inc(t.port, C_MULTI_COL);
            end
            if (t.deferred) inc(t.port, C_DEFER);
            if (t.excess_col) inc(t.port, C_EXC_COL);
            if (sel ? (t.crc_mismatch | t.underrun) : t.queue_drop) begin
                inc(t.port, C_TX_DATA_ERR);
            end
        end
        if (v && u.port < NUM_PORTS) begin
            if (u.jam && u.port >= NUM_FAST_PORTS) inc(u.port, C_COLL);
            if (u.crs_lost && !crs_l[u.port]) begin
                inc(u.port, C_CRS_ERR);
                crs_l[u.port] = 1'b1;
            end
            if (u.late_col) inc(u.port, C_LATE_COL);
            if (u.overrun) inc(u.port, C_OVERRUN);
            if (u.addr_mismatch) begin
                inc(u.port, C_ADDR_MISM);
                exp_s[u.port] = 1'b1;
            end
        end
    endtask
    task automatic traffic(input int n);
        psc_rx_evt_t r;
        psc_tx_evt_t t;
        psc_pulse_t u;
        logic [47:0] w;
        repeat (n) begin
            repeat (3) begin
                lf = lfsr(lf);
                w = {w[31:0], lf};
            end
            r = w[23:0];
            t = w[47:18];
            u = w[40:32];
            r.len = LENS[w[11:8] % 15];
            t.len = LENS[w[15:12] % 15];
            t.bcast &= t.success;
            t.mcast &= t.success;
            if (t.done && t.port == u.port) u.crs_lost = 1'b0;
            upd(r, t, u, w[44]);
            phy.fire(r, t, u, w[44]);
        end
        phy.fire('0, '0, '0, 1'b0);
    endtask
    task automatic clear();
        foreach (exp_c[p, i]) exp_c[p][i] = CNT_ZERO;
        exp_s = '0;
        crs_l = '0;
    endtask
    task automatic check_all();
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int i = 0; i <= CTR_N; i++) begin
                @(posedge clk);
                rd_port <= p[PORT_W-1:0];
                rd_idx <= i[4:0];
                rd_req <= 1'b1;
                q.push_back(i < CTR_N ? exp_c[p][i] : CNT_ZERO);
            end
        end
        @(posedge clk);
        rd_req <= 1'b0;
        repeat (3) @(posedge clk);
        check("suspend", CNT_W'(susp), CNT_W'(exp_s));
    endtask
    always @(posedge clk) rd_d <= rd_req;
    // Read data settles one edge after the select; sample mid-cycle
    always @(negedge clk) begin
        if (rd_d) begin
            check("rd_data", rd_data, q.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        clear();
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        check_all();
        for (int ph = 0; ph < 4; ph++) begin
            @(posedge clk);
            long_r <= ph[0];
            sel <= ph[1];
            @(posedge clk);
            traffic(150);
            check_all();
        end
        traffic(50);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        clear();
        check_all();
        finish_test();
    end
endmodule
